/* verilog/ivpr_defines.vh */
// constants for the interrupt vector priority resolver
`ifndef IVPR_DEFINES_VH
`define IVPR_DEFINES_VH

`define IVPR_VEC_W        7
`define IVPR_NUM_VEC      128
`define IVPR_ADDR_W       24
`define IVPR_ADDR_PAD     15'h0000
`define IVPR_ADDR_LSB     2'h0
`define IVPR_SEL_W        32

`define IVPR_VEC_NMI      7'h07
`define IVPR_VEC_EXT_LO   7'h10
`define IVPR_VEC_SWDT     7'h18
`define IVPR_VEC_WDT0     7'h19
`define IVPR_VEC_WDT1     7'h1a
`define IVPR_VEC_BRK      7'h1b
`define IVPR_VEC_ADC      7'h1c
`define IVPR_VEC_EVT      7'h1d
`define IVPR_VEC_TMRX     7'h2c
`define IVPR_VEC_FRT      7'h34
`define IVPR_VEC_EXT_HI   7'h38
`define IVPR_VEC_TMR0     7'h40
`define IVPR_VEC_TMR1     7'h44
`define IVPR_VEC_TMRY     7'h48
`define IVPR_VEC_TW2      7'h4c
`define IVPR_VEC_TW3      7'h4e
`define IVPR_VEC_SER3     7'h50
`define IVPR_VEC_SER1     7'h54
`define IVPR_VEC_TW0      7'h5e
`define IVPR_VEC_TW1      7'h62
`define IVPR_VEC_HOST     7'h68

// positions inside level_select_bits: bytes a, b, c, d from high to low
`define IVPR_LV_A7        31
`define IVPR_LV_A6        30
`define IVPR_LV_A5        29
`define IVPR_LV_A4        28
`define IVPR_LV_A3        27
`define IVPR_LV_A2        26
`define IVPR_LV_A1        25
`define IVPR_LV_A0        24
`define IVPR_LV_B7        23
`define IVPR_LV_B6        22
`define IVPR_LV_B4        20
`define IVPR_LV_B3        19
`define IVPR_LV_B2        18
`define IVPR_LV_B1        17
`define IVPR_LV_C7        15
`define IVPR_LV_C6        14
`define IVPR_LV_C4        12
`define IVPR_LV_C3        11
`define IVPR_LV_C2        10
`define IVPR_LV_C1        9
`define IVPR_LV_D7        7
`define IVPR_LV_D6        6

`endif

/* verilog/ivpr_resolver.v */
// interrupt vector priority resolver
`include "ivpr_defines.vh"
`timescale 1ns/100ps
`default_nettype none

module ivpr_resolver
(
  input  wire         sys_clk,
  input  wire         rst,
  input  wire         ce,
  input  wire         nmi_request,
  input  wire [15:0]  external_request,
  input  wire         sw_transfer_end_request,
  input  wire         watchdog0_interval_request,
  input  wire         watchdog1_interval_request,
  input  wire         address_break_request,
  input  wire         conversion_done_request,
  input  wire         event_input_request,
  input  wire [2:0]   timer_x_request,
  input  wire [2:0]   frt_request,
  input  wire [2:0]   timer0_request,
  input  wire [2:0]   timer1_request,
  input  wire [2:0]   timer_y_request,
  input  wire [3:0]   twowire_request,
  input  wire [3:0]   serial3_request,
  input  wire [3:0]   serial1_request,
  input  wire [3:0]   host_port_request,
  input  wire [31:0]  level_select_bits,
  output reg          irq_pending,
  output reg  [6:0]   irq_vector,
  output reg  [23:0]  irq_address
);

  // pin inputs pass two flip-flops
  reg  [16:0]                   pin_meta;
  reg  [16:0]                   pin_sync;
  reg  [`IVPR_NUM_VEC-1:0]      pend;
  reg  [`IVPR_NUM_VEC-1:0]      level1;
  reg  [7:0]                    win_hi;
  reg  [7:0]                    win_any;
  reg                           next_pending;
  reg  [`IVPR_VEC_W-1:0]        next_vector;
  wire                          nmi_s;
  wire [15:0]                   ext_s;

  assign nmi_s = pin_sync[16];
  assign ext_s = pin_sync[15:0];

  // lowest set index wins; msb of result flags a hit
  function [7:0] lowest_set;
    input [`IVPR_NUM_VEC-1:0] v;
    integer k;
    begin
      lowest_set = 8'h00;
      for (k = `IVPR_NUM_VEC - 1; k >= 0; k = k - 1)
        if (v[k])
          lowest_set = {1'b1, k[6:0]};
    end
  endfunction

  always @(posedge sys_clk)
  begin
    if (rst)
    begin
      pin_meta <= 17'h00000;
      pin_sync <= 17'h00000;
    end
    else if (ce)
    begin
      pin_meta <= {nmi_request, external_request};
      pin_sync <= pin_meta;
    end
  end

  // map every source onto its vector number
  always @*
  begin
    pend = {`IVPR_NUM_VEC{1'b0}};
    pend[`IVPR_VEC_NMI] = nmi_s;
    pend[`IVPR_VEC_EXT_LO +: 8] = ext_s[7:0];
    pend[`IVPR_VEC_SWDT] = sw_transfer_end_request;
    pend[`IVPR_VEC_WDT0] = watchdog0_interval_request;
    pend[`IVPR_VEC_WDT1] = watchdog1_interval_request;
    pend[`IVPR_VEC_BRK] = address_break_request;
    pend[`IVPR_VEC_ADC] = conversion_done_request;
    pend[`IVPR_VEC_EVT] = event_input_request;
    pend[`IVPR_VEC_TMRX +: 3] = timer_x_request;
    pend[`IVPR_VEC_FRT +: 3] = frt_request;
    pend[`IVPR_VEC_EXT_HI +: 8] = ext_s[15:8];
    pend[`IVPR_VEC_TMR0 +: 3] = timer0_request;
    pend[`IVPR_VEC_TMR1 +: 3] = timer1_request;
    pend[`IVPR_VEC_TMRY +: 3] = timer_y_request;
    pend[`IVPR_VEC_TW2] = twowire_request[2];
    pend[`IVPR_VEC_TW3] = twowire_request[3];
    pend[`IVPR_VEC_TW0] = twowire_request[0];
    pend[`IVPR_VEC_TW1] = twowire_request[1];
    pend[`IVPR_VEC_SER3 +: 4] = serial3_request;
    pend[`IVPR_VEC_SER1 +: 4] = serial1_request;
    pend[`IVPR_VEC_HOST +: 4] = host_port_request;
  end

  // control level per vector; sources with no select bit stay at level zero
  always @*
  begin
    level1 = {`IVPR_NUM_VEC{1'b0}};
    level1[`IVPR_VEC_EXT_LO]     = level_select_bits[`IVPR_LV_A7];
    level1[`IVPR_VEC_EXT_LO + 1] = level_select_bits[`IVPR_LV_A6];
    level1[`IVPR_VEC_EXT_LO + 2 +: 2] = {2{level_select_bits[`IVPR_LV_A5]}};
    level1[`IVPR_VEC_EXT_LO + 4 +: 2] = {2{level_select_bits[`IVPR_LV_A4]}};
    level1[`IVPR_VEC_EXT_LO + 6 +: 2] = {2{level_select_bits[`IVPR_LV_A3]}};
    level1[`IVPR_VEC_SWDT] = level_select_bits[`IVPR_LV_A2];
    level1[`IVPR_VEC_WDT0] = level_select_bits[`IVPR_LV_A1];
    level1[`IVPR_VEC_WDT1] = level_select_bits[`IVPR_LV_A0];
    level1[`IVPR_VEC_ADC]  = level_select_bits[`IVPR_LV_B7];
    level1[`IVPR_VEC_TMRX +: 3] = {3{level_select_bits[`IVPR_LV_B4]}};
    level1[`IVPR_VEC_FRT +: 3]  = {3{level_select_bits[`IVPR_LV_B6]}};
    level1[`IVPR_VEC_EXT_HI +: 4] = {4{level_select_bits[`IVPR_LV_D7]}};
    level1[`IVPR_VEC_EXT_HI + 4 +: 4] = {4{level_select_bits[`IVPR_LV_D6]}};
    level1[`IVPR_VEC_TMR0 +: 3] = {3{level_select_bits[`IVPR_LV_B3]}};
    level1[`IVPR_VEC_TMR1 +: 3] = {3{level_select_bits[`IVPR_LV_B2]}};
    level1[`IVPR_VEC_TMRY +: 3] = {3{level_select_bits[`IVPR_LV_B1]}};
    level1[`IVPR_VEC_TW2] = level_select_bits[`IVPR_LV_C2];
    level1[`IVPR_VEC_TW0] = level_select_bits[`IVPR_LV_C4];
    level1[`IVPR_VEC_TW1] = level_select_bits[`IVPR_LV_C3];
    level1[`IVPR_VEC_SER3 +: 4] = {4{level_select_bits[`IVPR_LV_C7]}};
    level1[`IVPR_VEC_SER1 +: 4] = {4{level_select_bits[`IVPR_LV_C6]}};
    level1[`IVPR_VEC_HOST +: 4] = {4{level_select_bits[`IVPR_LV_C1]}};
  end

  // nmi first, then level one in default order, then everything in default order
  always @*
  begin
    win_hi  = lowest_set(pend & level1);
    win_any = lowest_set(pend);
    next_pending = 1'b0;
    next_vector  = {`IVPR_VEC_W{1'b0}};
    if (nmi_s)
    begin
      next_pending = 1'b1;
      next_vector  = `IVPR_VEC_NMI;
    end
    else if (win_hi[7])
    begin
      next_pending = 1'b1;
      next_vector  = win_hi[6:0];
    end
    else if (win_any[7])
    begin
      next_pending = 1'b1;
      next_vector  = win_any[6:0];
    end
  end

  // chosen vector re-resolved every cycle with ce high, so losers are never dropped
  always @(posedge sys_clk)
  begin
    if (rst)
    begin
      irq_pending <= 1'b0;
      irq_vector  <= {`IVPR_VEC_W{1'b0}};
      irq_address <= {`IVPR_ADDR_W{1'b0}};
    end
    else if (ce)
    begin
      irq_pending <= next_pending;
      irq_vector  <= next_vector;
      irq_address <= {`IVPR_ADDR_PAD, next_vector, `IVPR_ADDR_LSB};
    end
  end

endmodule

`default_nettype wire

/* bench/ivpr_resolver_monitor.sv */
// assertions on the resolver ports
`timescale 1ns/100ps
`default_nettype none
module ivpr_resolver_monitor
(
  input wire logic        sys_clk,
  input wire logic        rst,
  input wire logic        ce,
  input wire logic        nmi_request,
  input wire logic [15:0] external_request,
  input wire logic [3:0]  host_port_request,
  input wire logic [31:0] level_select_bits,
  input wire logic        irq_pending,
  input wire logic [6:0]  irq_vector,
  input wire logic [23:0] irq_address
);
  localparam logic [127:0] legal_vec = 128'h00000f04_40ff5777_ff707000_3fff0080;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  addr_map_a: assert property (irq_address == {15'h0000, irq_vector, 2'h0})
    else $error("address is not vector times four");
  idle_zero_a: assert property (!irq_pending |-> irq_vector == 7'h00)
    else $error("vector shown while idle");
  reset_out_a: assert property (disable iff (1'b0) rst && ce |=> !irq_pending && irq_address == 24'h000000)
    else $error("outputs not cleared by reset");
  nmi_win_a: assert property ((ce && nmi_request) [*4] |=> irq_pending && irq_vector == 7'h07)
    else $error("pin request did not win");
  output_freeze_a: assert property (!ce |=> $stable(irq_vector) && $stable(irq_pending))
    else $error("outputs moved while disabled");
  level_win_a: assert property ((ce && !nmi_request && host_port_request[0]
    && level_select_bits == 32'h00000200) [*4] |=> irq_vector == 7'h68)
    else $error("level one module did not win");
  default_win_a: assert property ((ce && !nmi_request && external_request[0]
    && level_select_bits == 32'h00000000) [*4] |=> irq_vector == 7'h10)
    else $error("lowest vector did not win");
  legal_vec_a: assert property (irq_pending |-> legal_vec[irq_vector])
    else $error("unused vector presented");
endmodule
bind ivpr_resolver ivpr_resolver_monitor i_mon (.sys_clk(sys_clk), .rst(rst), .ce(ce), .nmi_request(nmi_request),
  .external_request(external_request), .host_port_request(host_port_request), .level_select_bits(level_select_bits),
  .irq_pending(irq_pending), .irq_vector(irq_vector), .irq_address(irq_address));
`default_nettype wire

/* bench/ivpr_core.sv */
// core model that services the winning vector and clears that source
`timescale 1ns/100ps
`default_nettype none
module ivpr_core
(
  input wire logic         sys_clk,
  input wire logic         ack_en,
  input wire logic         irq_pending,
  input wire logic [6:0]   irq_vector,
  input wire logic [127:0] set_req,
  output logic     [127:0] req
);
  logic [127:0] served = 128'h0;
  assign req = set_req & ~served;
  always @(posedge sys_clk)
    if (!ack_en) served <= 128'h0;
    else if (irq_pending) served <= served | (128'h1 << irq_vector);
endmodule
`default_nettype wire

/* bench/tb.sv */
// testbench for the interrupt vector priority resolver
`timescale 1ns/100ps
`default_nettype none
module tb;
  localparam logic [127:0] legal_vec = 128'h00000f04_40ff5777_ff707000_3fff0080;
  localparam logic [127:0] nobit = 128'h00000800_00004000_00000000_28000000;
  logic         sys_clk = 1'b0;
  logic         rst = 1'b1;
  logic         ce = 1'b1;
  logic         ack_en = 1'b0;
  logic [127:0] set_req = 128'h0;
  logic [31:0]  lsel = 32'h0;
  wire  [127:0] req;
  wire          irq_pending;
  wire  [6:0]   irq_vector;
  wire  [23:0]  irq_address;
  int           fail_count = 0;
  int           compares = 0;
  int           n;
  logic [6:0]   exp_lv [0:31] = '{7'h10, 7'h10, 7'h10, 7'h10, 7'h10, 7'h10, 7'h3c, 7'h38, 7'h10, 7'h68, 7'h4c,
    7'h62, 7'h5e, 7'h10, 7'h54, 7'h50, 7'h10, 7'h48, 7'h44, 7'h40, 7'h2c, 7'h10, 7'h34, 7'h1c, 7'h1a, 7'h19,
    7'h18, 7'h16, 7'h14, 7'h12, 7'h11, 7'h10};
  initial forever #10 sys_clk = ~sys_clk;
  ivpr_core i_ivpr_core (.sys_clk(sys_clk), .ack_en(ack_en), .irq_pending(irq_pending), .irq_vector(irq_vector),
    .set_req(set_req), .req(req));
  ivpr_resolver i_ivpr_resolver (.sys_clk(sys_clk), .rst(rst), .ce(ce), .nmi_request(req[7]),
    .external_request({req[63:56], req[23:16]}), .sw_transfer_end_request(req[24]),
    .watchdog0_interval_request(req[25]), .watchdog1_interval_request(req[26]), .address_break_request(req[27]),
    .conversion_done_request(req[28]), .event_input_request(req[29]), .timer_x_request(req[46:44]),
    .frt_request(req[54:52]), .timer0_request(req[66:64]), .timer1_request(req[70:68]),
    .timer_y_request(req[74:72]), .twowire_request({req[78], req[76], req[98], req[94]}),
    .serial3_request(req[83:80]), .serial1_request(req[87:84]), .host_port_request(req[107:104]),
    .level_select_bits(lsel), .irq_pending(irq_pending), .irq_vector(irq_vector), .irq_address(irq_address));
  task summarize;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task chk(input logic [6:0] v, input logic p);
    repeat (5) @(negedge sys_clk);
    compares++;
    if (irq_pending !== p || irq_vector !== v || irq_address !== {15'h0000, v, 2'h0})
    begin
      $display("mismatch t=%0t got %h exp %h", $time, {irq_pending, irq_vector, irq_address},
        {p, v, 15'h0000, v, 2'h0});
      fail_count++;
    end
  endtask
  task set(input logic [127:0] r, input logic [31:0] l);
    @(posedge sys_clk);
    set_req <= r;
    lsel <= l;
  endtask
  task t_single;
    for (int v = 0; v < 128; v++)
    begin
      set(128'h1 << v, 32'h0);
      chk(legal_vec[v] ? v[6:0] : 7'h00, legal_vec[v]);
    end
  endtask
  task t_level;
    for (int i = 0; i < 32; i++)
    begin
      set(legal_vec & ~(128'h1 << 7), 32'h1 << i);
      chk(exp_lv[i], 1'b1);
    end
  endtask
  task t_ce;
    set(128'h1 << 24, 32'h0);
    chk(7'h18, 1'b1);
    @(posedge sys_clk);
    ce <= 1'b0;
    set_req <= 128'h1 << 25;
    chk(7'h18, 1'b1);
    @(posedge sys_clk);
    ce <= 1'b1;
    chk(7'h19, 1'b1);
  endtask
  task t_drain;
    set(legal_vec, 32'h0);
    chk(7'h07, 1'b1);
    @(posedge sys_clk);
    ack_en <= 1'b1;
    for (int v = 0; v < 128; v++)
      if (legal_vec[v])
      begin
        n = 0;
        do
        begin
          @(negedge sys_clk);
          n++;
        end
        while (irq_vector !== v[6:0] && n < 40);
        compares++;
        if (irq_vector !== v[6:0])
        begin
          $display("mismatch t=%0t got %h exp %h", $time, irq_vector, v[6:0]);
          fail_count++;
          summarize;
        end
      end
    chk(7'h00, 1'b0);
    set(128'h0, 32'h0);
    ack_en <= 1'b0;
  endtask
  initial
  begin
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    chk(7'h00, 1'b0);
    t_single;
    t_level;
    set(nobit, 32'hffffffff);
    chk(7'h6b, 1'b1);
    set(nobit, 32'h0);
    chk(7'h1b, 1'b1);
    t_ce;
    t_drain;
    summarize;
  end
endmodule
`default_nettype wire
